// *** shared/swcp_pkg.sv ***
package swcp_pkg;

    // Clock and basic clock period, in picoseconds.
    localparam int CLK_PERIOD_PS = 10000;
    localparam int BCP_PS = 2038200;
    localparam int BCP_CYCLES = BCP_PS / CLK_PERIOD_PS;

    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_LIMIT = 8'h00;
    localparam logic [7:0] ADDR_POLL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // Upper bit-check limit field and limit scale factor.
    localparam int LIM_W = 6;
    localparam logic [5:0] LIM_LOW_BOUND = 6'h0C;
    localparam logic [5:0] LIM_HIGH_BOUND = 6'h3F;
    localparam logic [5:0] LIM_DEFAULT = 6'h29;
    localparam int LIM_SCALE_LSB = 8;
    localparam logic [3:0] LIM_SCALE_DEFAULT = 4'h1;

    // Polling configuration word programmed over the data line.
    localparam int WORD_W = 15;
    localparam logic [14:0] POLL_DEFAULT = 15'h0000;
    localparam int OFF_BIT = 1;
    localparam logic [3:0] BIT_COUNT = 4'hF;

    // Status register field positions.
    localparam int ST_BEACON = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_ACK = 2;
    localparam int ST_OFF = 3;

    // Link timing, in basic clock periods.
    localparam logic [15:0] T1_MIN = 16'h0010;
    localparam logic [15:0] T1_SHORT_MAX = 16'h1600;
    localparam logic [15:0] T1_LONG = 16'h1F00;
    localparam logic [15:0] T2_DELAY = 16'h0010;
    localparam logic [15:0] T3_SYNC = 16'h0008;
    localparam logic [15:0] T4_GAP = 16'h0008;
    localparam logic [15:0] T5_WIN = 16'h0020;
    localparam logic [15:0] T6_FRAME = 16'h0040;
    localparam logic [15:0] T7_PROG = 16'h0004;
    localparam logic [15:0] T8_ACK = 16'h0008;
    localparam logic [15:0] T9_EQ = 16'h0020;
    localparam logic [15:0] BEACON_HALF = 16'h0400;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } swcp_bus_req_t;

    typedef struct packed {
        logic off_seen;
        logic last_ack;
        logic busy;
        logic beacon_active;
    } swcp_status_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_DELAY,
        S_SYNC,
        S_GAP,
        S_WIN,
        S_REST,
        S_EQ
    } swcp_state_t;

endpackage

// *** verilog/swcp_tick.sv ***
`timescale 1ns/10ps
module swcp_tick
    import swcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    logic [15:0] cnt;

    // Emits one enable pulse per basic clock period.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt == 16'(BCP_CYCLES - 1)) begin
            cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// *** verilog/swcp_beacon.sv ***
`timescale 1ns/10ps
module swcp_beacon
    import swcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic enable,
    output logic drive_low
);
    logic [15:0] cnt;
    logic phase;

    // Square wave with equal high and low halves while enabled.
    always_ff @(posedge core_clk) begin
        if (rst || !enable) begin
            cnt <= 16'h0000;
            phase <= 1'b0;
        end else if (tick) begin
            if (cnt == BEACON_HALF - 16'h0001) begin
                cnt <= 16'h0000;
                phase <= ~phase;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    assign drive_low = enable && phase;
endmodule

// *** verilog/swcp_core.sv ***
// Behaviour
// - Six-bit upper limit 12..63, default 41.
// - Upper limit sets clock recovery tolerance margins.
// - Power-on reset loads all configuration defaults.
// - After reset drive 50% square-wave beacon.
// - Beacon slower than any valid data signal.
// - Host low start pulse; device then masters line.
// - After delay emit 15 synchronisation pulses.
// - Each pulse followed by delayed programming window.
// - Host low pulse stores 0, none stores 1.
// - Acknowledge pulse only when new word matches stored.
// - Programming accepted while sleeping or receiving.
// - Receive path disabled during programming.
// - Word bit 1 set means off command.
// - Short start ignored while in reset state.
// - Long start works whenever idle, beacon or not, restores defaults, clears beacon.
`timescale 1ns/10ps
module swcp_core
    import swcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire swcp_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire logic data_in,
    output logic data_out,
    output logic data_oe,
    input wire logic sleep_mode,
    output logic rx_path_enable,
    output logic poll_mode_req,
    output logic [9:0] limit_time,
    output logic [9:0] recovery_margin_hi,
    output logic [9:0] recovery_margin_lo
);
    swcp_state_t state;
    swcp_state_t next_state;
    swcp_status_t status;
    logic tick;
    logic beacon_low;
    logic [5:0] limit_value;
    logic [3:0] limit_scale;
    logic [14:0] poll_word;
    logic [14:0] shift_word;
    logic [15:0] tcnt;
    logic [15:0] low_cnt;
    logic [15:0] win_low_cnt;
    logic [3:0] bit_idx;
    logic bit_zero;
    logic ack_match;
    logic start_long;
    logic start_short;
    logic release_seen;
    logic state_done;
    logic drive_low;

    // True on the tick that closes a phase of the given length.
    function automatic logic phase_end(input logic [15:0] count, input logic [15:0] len);
        phase_end = (count == len - 16'h0001);
    endfunction

    swcp_tick u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick)
    );

    // The beacon half period far exceeds the largest bit-check time.
    swcp_beacon u_beacon (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick),
        .enable(status.beacon_active && state == S_IDLE),
        .drive_low(beacon_low)
    );

    // Length of the current low level in basic clock periods.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            low_cnt <= 16'h0000;
        end else if (tick) begin
            if (!data_in) begin
                if (low_cnt != 16'hFFFF) begin
                    low_cnt <= low_cnt + 16'h0001;
                end
            end else begin
                low_cnt <= 16'h0000;
            end
        end
    end

    // Start pulse classification on the release of the line.
    assign release_seen = tick && data_in && (low_cnt != 16'h0000) && (state == S_IDLE);
    assign start_long = release_seen && (low_cnt > T1_LONG);
    assign start_short = release_seen && (low_cnt > T1_MIN) && (low_cnt < T1_SHORT_MAX)
        && !status.beacon_active;

    // Phase timer, restarted on every state change.
    always_ff @(posedge core_clk) begin
        if (rst || next_state != state) begin
            tcnt <= 16'h0000;
        end else if (tick) begin
            tcnt <= tcnt + 16'h0001;
        end
    end

    always_comb begin
        state_done = 1'b0;
        case (state)
            S_DELAY: state_done = phase_end(tcnt, T2_DELAY);
            S_SYNC: state_done = phase_end(tcnt, T3_SYNC);
            S_GAP: state_done = phase_end(tcnt, T4_GAP);
            S_WIN: state_done = phase_end(tcnt, T5_WIN);
            S_REST: state_done = phase_end(tcnt, T6_FRAME - T3_SYNC - T4_GAP - T5_WIN);
            S_EQ: state_done = phase_end(tcnt, T9_EQ);
            default: state_done = 1'b0;
        endcase
    end

    // Sequencer of start, sync pulses, windows and equivalence window.
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (start_long || start_short) begin
                    next_state = S_DELAY;
                end
            end
            S_DELAY: begin
                if (tick && state_done) begin
                    next_state = S_SYNC;
                end
            end
            S_SYNC: begin
                if (tick && state_done) begin
                    next_state = S_GAP;
                end
            end
            S_GAP: begin
                if (tick && state_done) begin
                    next_state = S_WIN;
                end
            end
            S_WIN: begin
                if (tick && state_done) begin
                    next_state = S_REST;
                end
            end
            S_REST: begin
                if (tick && state_done) begin
                    if (bit_idx == BIT_COUNT - 4'h1) begin
                        next_state = S_EQ;
                    end else begin
                        next_state = S_SYNC;
                    end
                end
            end
            S_EQ: begin
                if (tick && state_done) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bit counter across the fifteen frames.
    always_ff @(posedge core_clk) begin
        if (rst || state == S_IDLE) begin
            bit_idx <= 4'h0;
        end else if (state == S_REST && next_state == S_SYNC) begin
            bit_idx <= bit_idx + 4'h1;
        end
    end

    // Host low pulse detection inside the programming window.
    always_ff @(posedge core_clk) begin
        if (rst || state == S_GAP) begin
            win_low_cnt <= 16'h0000;
            bit_zero <= 1'b0;
        end else if (state == S_WIN && tick) begin
            if (!data_in) begin
                win_low_cnt <= win_low_cnt + 16'h0001;
                if (win_low_cnt + 16'h0001 >= T7_PROG) begin
                    bit_zero <= 1'b1;
                end
            end else begin
                win_low_cnt <= 16'h0000;
            end
        end
    end

    // Received word, first bit into the most significant position.
    always_ff @(posedge core_clk) begin
        if (rst || state == S_IDLE) begin
            shift_word <= 15'h0000;
        end else if (state == S_WIN && next_state == S_REST) begin
            shift_word <= {shift_word[13:0], ~bit_zero};
        end
    end

    // Equivalence compare made as the window opens.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_match <= 1'b0;
        end else if (state == S_REST && next_state == S_EQ) begin
            ack_match <= (shift_word == poll_word);
        end
    end

    // Configuration registers with reset and long-start defaults.
    always_ff @(posedge core_clk) begin
        if (rst || start_long) begin
            limit_value <= LIM_DEFAULT;
            limit_scale <= LIM_SCALE_DEFAULT;
            poll_word <= POLL_DEFAULT;
        end else if (state == S_EQ && next_state == S_IDLE) begin
            poll_word <= shift_word;
        end else if (bus_req.wr) begin
            if (bus_req.addr == ADDR_LIMIT) begin
                if (bus_req.wdata[5:0] >= LIM_LOW_BOUND
                    && bus_req.wdata[5:0] <= LIM_HIGH_BOUND) begin
                    limit_value <= bus_req.wdata[5:0];
                end
                limit_scale <= bus_req.wdata[LIM_SCALE_LSB +: 4];
            end else if (bus_req.addr == ADDR_POLL) begin
                poll_word <= bus_req.wdata[WORD_W-1:0];
            end
        end
    end

    // Status flags.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status.beacon_active <= 1'b1;
            status.last_ack <= 1'b0;
            status.off_seen <= 1'b0;
            status.busy <= 1'b0;
        end else begin
            status.busy <= (next_state != S_IDLE);
            if (start_long) begin
                status.beacon_active <= 1'b0;
            end
            if (state == S_REST && next_state == S_EQ) begin
                status.last_ack <= (shift_word == poll_word);
            end
            if (state == S_EQ && next_state == S_IDLE) begin
                status.off_seen <= shift_word[OFF_BIT];
            end
        end
    end

    // Off command returns the receiver to polling mode.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            poll_mode_req <= 1'b0;
        end else begin
            poll_mode_req <= (state == S_EQ) && (next_state == S_IDLE)
                && shift_word[OFF_BIT];
        end
    end

    // Bit-check time limit and recovery tolerance margins.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            limit_time <= 10'h000;
            recovery_margin_hi <= 10'h000;
            recovery_margin_lo <= 10'h000;
        end else begin
            limit_time <= (10'(limit_value) - 10'h001) * 10'(limit_scale);
            recovery_margin_hi <= 10'(limit_value) * 10'(limit_scale);
            recovery_margin_lo <= (10'(limit_value) - 10'h002) * 10'(limit_scale);
        end
    end

    // Receive path is off for the whole sequence.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_path_enable <= 1'b0;
        end else begin
            rx_path_enable <= (next_state == S_IDLE) && !sleep_mode;
        end
    end

    // Open-drain line driver: sync pulses, acknowledge, beacon.
    always_comb begin
        drive_low = 1'b0;
        case (state)
            S_IDLE: drive_low = beacon_low;
            S_SYNC: drive_low = 1'b1;
            S_EQ: drive_low = ack_match && (tcnt < T8_ACK);
            default: drive_low = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= drive_low;
        end
    end

    assign data_out = 1'b0;

    // Register read port, data in the cycle after the strobe.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_LIMIT: rdata <= {20'h00000, limit_scale, 2'h0, limit_value};
                ADDR_POLL: rdata <= {17'h00000, poll_word};
                ADDR_STATUS: rdata <= {28'h0000000, status};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end
endmodule

// *** bench/swcp_core_asserts.sv ***
`timescale 1ns/10ps
module swcp_core_asserts
    import swcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire swcp_bus_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic sleep_mode,
    input wire logic rx_path_enable,
    input wire logic poll_mode_req,
    input wire logic [9:0] limit_time,
    input wire logic [9:0] recovery_margin_hi,
    input wire logic [9:0] recovery_margin_lo
);
    logic [31:0] hi_len;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Counts how long the device has been pulling the line low.
    always_ff @(posedge core_clk) begin
        if (rst || !data_oe) begin
            hi_len <= 32'h0;
        end else begin
            hi_len <= hi_len + 32'h1;
        end
    end
    property p_open_drain;
        data_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_lim_range;
        bus_req.rd && bus_req.addr == ADDR_LIMIT |=> rdata[5:0] >= LIM_LOW_BOUND;
    endproperty
    a_lim_range: assert property (p_lim_range) else $error("limit below range");
    property p_margins;
        !$past(rst) && !$past(rst, 2) |->
            recovery_margin_hi - limit_time == limit_time - recovery_margin_lo;
    endproperty
    a_margins: assert property (p_margins) else $error("margins not centred");
    property p_default;
        $fell(rst) |-> ##[0:2] limit_time == 10'h028;
    endproperty
    a_default: assert property (p_default) else $error("limit default wrong");
    property p_poll_pulse;
        poll_mode_req |=> !poll_mode_req;
    endproperty
    a_poll_pulse: assert property (p_poll_pulse) else $error("poll request long");
    property p_poll_rx;
        poll_mode_req |-> !$past(rx_path_enable);
    endproperty
    a_poll_rx: assert property (p_poll_rx) else $error("receive path on");
    property p_sleep;
        $past(sleep_mode) |-> !rx_path_enable;
    endproperty
    a_sleep: assert property (p_sleep) else $error("receive path on asleep");
    property p_oe_run;
        $fell(data_oe) |-> (hi_len > 7 * BCP_CYCLES - 3 && hi_len < 9 * BCP_CYCLES + 3)
            || (hi_len > 1023 * BCP_CYCLES && hi_len < 1025 * BCP_CYCLES);
    endproperty
    a_oe_run: assert property (p_oe_run) else $error("low pulse length wrong");
endmodule
bind swcp_core swcp_core_asserts u_chk (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .sleep_mode(sleep_mode), .rx_path_enable(rx_path_enable), .poll_mode_req(poll_mode_req),
    .limit_time(limit_time), .recovery_margin_hi(recovery_margin_hi),
    .recovery_margin_lo(recovery_margin_lo));

// *** bench/swcp_host.sv ***
`timescale 1ns/10ps
module swcp_host
    import swcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic dev_oe,
    output logic line
);
    logic host_low = 1'b0;
    // The pulled-up line is low while either side pulls it down.
    assign line = !(host_low || dev_oe);
    task automatic wait_p(input int n);
        repeat (n * BCP_CYCLES) @(posedge core_clk);
    endtask
    task automatic wait_oe(input int n, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < n * BCP_CYCLES && !seen; i++) begin
            @(posedge core_clk);
            #1 seen = dev_oe;
        end
    endtask
    task automatic start(input int t1);
        host_low <= 1'b1;
        wait_p(t1);
        host_low <= 1'b0;
    endtask
    task automatic transfer(input int t1, input int late, input logic [14:0] word,
                            output logic ok, output logic ack);
        logic seen;
        ok = 1'b1;
        start(t1);
        // The beacon may still hold the line low after the host lets go.
        while (!line) begin
            @(posedge core_clk);
        end
        for (int b = 14; b >= 0 && ok; b--) begin
            wait_oe(b == 14 ? 1100 : 60, seen);
            ok = seen;
            wait_p(late);
            host_low <= !word[b];
            wait_p(6);
            host_low <= 1'b0;
        end
        wait_oe(50, ack);
        wait_p(40);
    endtask
endmodule

// *** bench/tb_single_wire_config_programming.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
$display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb_single_wire_config_programming
    import swcp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    swcp_bus_req_t bus_req = '0;
    logic sleep_mode = 1'b0;
    logic [31:0] rdata;
    logic data_in, data_out, data_oe, rx_path_enable, poll_mode_req, ok, ack, seen;
    logic [9:0] limit_time, hi, lo;
    logic [31:0] rd_val;
    logic [31:0] lim_w[3] = '{32'h20B, 32'h13F, 32'h10C};
    logic [31:0] lim_r[3] = '{32'h229, 32'h13F, 32'h10C};
    logic [9:0] lim_t[3] = '{10'h050, 10'h03E, 10'h00B};
    logic [9:0] lim_h[3] = '{10'h052, 10'h03F, 10'h00C};
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_poll = 0;
    int run;
    swcp_core u_dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .sleep_mode(sleep_mode),
        .rx_path_enable(rx_path_enable), .poll_mode_req(poll_mode_req),
        .limit_time(limit_time), .recovery_margin_hi(hi), .recovery_margin_lo(lo));
    swcp_host u_host (.core_clk(core_clk), .dev_oe(data_oe), .line(data_in));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        n_poll += (poll_mode_req === 1'b1);
        if (cyc == 5000000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1 d = rdata;
        @(posedge core_clk);
    endtask
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (data_oe === lvl && n < 300000) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(ADDR_LIMIT, rd_val);
        `CHK("limit", 32'h129, rd_val)
        rd(ADDR_POLL, rd_val);
        `CHK("poll", 32'h0, rd_val)
        rd(ADDR_STATUS, rd_val);
        `CHK("status", 32'h1, rd_val)
        rd(8'h0C, rd_val);
        `CHK("unmapped", 32'h0, rd_val)
        `CHK("margin_hi", 10'h029, hi)
        `CHK("margin_lo", 10'h027, lo)
        `CHK("limit_time", 10'h028, limit_time)
        foreach (lim_w[i]) begin
            wr(ADDR_LIMIT, lim_w[i]);
            rd(ADDR_LIMIT, rd_val);
            `CHK("limit", lim_r[i], rd_val)
            `CHK("limit_time", lim_t[i], limit_time)
            `CHK("margin_hi", lim_h[i], hi)
        end
        run_len(1'b1, run);
        run_len(1'b0, run);
        run_len(1'b1, run);
        `CHK("beacon_hi", 1'b1, run > 1023 * BCP_CYCLES && run < 1025 * BCP_CYCLES)
        run_len(1'b0, run);
        `CHK("beacon_lo", 1'b1, run > 1023 * BCP_CYCLES && run < 1025 * BCP_CYCLES)
        u_host.start(200);
        u_host.wait_p(100);
        rd(ADDR_STATUS, rd_val);
        `CHK("status", 32'h1, rd_val)
        fork
            u_host.transfer(7950, 24, 15'h5A5C, ok, ack);
            begin
                u_host.wait_p(7960);
                run_len(1'b1, run);
                u_host.wait_oe(1100, seen);
                `CHK("rx_path", 1'b0, rx_path_enable)
            end
        join
        `CHK("syncs", 1'b1, ok)
        `CHK("ack", 1'b0, ack)
        rd(ADDR_POLL, rd_val);
        `CHK("poll", 32'h5A5C, rd_val)
        rd(ADDR_LIMIT, rd_val);
        `CHK("limit", 32'h129, rd_val)
        rd(ADDR_STATUS, rd_val);
        `CHK("status", 32'h0, rd_val)
        sleep_mode <= 1'b1;
        u_host.transfer(300, 38, 15'h5A5C, ok, ack);
        `CHK("syncs", 1'b1, ok)
        `CHK("ack", 1'b1, ack)
        `CHK("n_poll", 0, n_poll)
        rd(ADDR_STATUS, rd_val);
        `CHK("status", 32'h4, rd_val)
        sleep_mode <= 1'b0;
        u_host.transfer(300, 24, 15'h0002, ok, ack);
        `CHK("ack", 1'b0, ack)
        `CHK("n_poll", 1, n_poll)
        rd(ADDR_STATUS, rd_val);
        `CHK("status", 32'h8, rd_val)
        finish_test();
    end
endmodule
